// ==== common/smr_pkg.sv ====
`default_nettype none
package smr_pkg;

  // ----------------------------------------------------------------
  // Command protocol modes and engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PROTO_ONE,
    PROTO_TWO,
    PROTO_FOUR
  } smr_proto_t;

  typedef enum logic [2:0] {
    ST_OPC,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } smr_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Configuration register one fields and the protocol mode
  typedef struct packed {
    logic [3:0] latencyCode;
    logic quadEnable;
    smr_proto_t protocolMode;
  } smr_cfg_t;

  // Array read request; data returns one cycle after en
  typedef struct packed {
    logic en;
    logic [20:0] addr;
  } smr_memreq_t;

  // ----------------------------------------------------------------
  // Opcodes, mode patterns, address space
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST = 8'h0b;
  localparam logic [7:0] OPC_DDR = 8'h0d;
  localparam logic [7:0] OPC_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OPC_DUAL_IO = 8'hbb;
  localparam logic [7:0] OPC_QUAD_OUT = 8'h6b;
  localparam logic [3:0] MODE_NIBBLE = 4'ha;
  localparam logic [7:0] MODE_DDR = 8'ha5;
  localparam int ADDR_W = 21;
  localparam logic [20:0] ADDR_TOP = 21'h1fffff;
  localparam logic [20:0] ADDR_BASE = 21'h000000;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------
  // Line widths and output enables
  // ----------------------------------------------------------------
  localparam logic [3:0] W_ONE = 4'h1;
  localparam logic [3:0] W_TWO = 4'h2;
  localparam logic [3:0] W_FOUR = 4'h4;
  localparam logic [3:0] OE_ONE = 4'h2;
  localparam logic [3:0] OE_TWO = 4'h3;
  localparam logic [3:0] OE_FOUR = 4'hf;
  localparam logic [3:0] OE_OFF = 4'h0;

  // Reset values
  localparam logic CONT_RST = 1'b0;
  localparam logic [7:0] CMD_RST = 8'h00;

endpackage : smr_pkg
`default_nettype wire

// ==== logic/smr_read_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module smr_read_engine (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sckPin,
  input wire logic csPin_n,
  input wire logic [3:0] ioIn,
  input wire smr_pkg::smr_cfg_t cfg,
  input wire logic [7:0] memRdData,
  output logic [3:0] ioOut_r,
  output logic [3:0] ioOe_r,
  output smr_pkg::smr_memreq_t memReq_r,
  output logic contActive_r
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sckSh_r;
  logic [2:0] csSh_r;
  logic [3:0] ioMeta_r;
  logic [3:0] ioSync_r;

  // Stage 0 is read only by stage 1; stage 2 is the edge reference
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sckSh_r <= 3'h0;
      csSh_r <= 3'h7;
      ioMeta_r <= 4'h0;
      ioSync_r <= 4'h0;
    end
    else
    begin
      sckSh_r <= {sckSh_r[1:0], sckPin};
      csSh_r <= {csSh_r[1:0], csPin_n};
      ioMeta_r <= ioIn;
      ioSync_r <= ioMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // Edge events and widths
  // ----------------------------------------------------------------
  logic riseEv, fallEv, csHigh, csFall, run;
  smr_pkg::smr_state_t state_r;
  logic [7:0] cmd_r;
  logic [7:0] shift_r;
  logic [7:0] shNxt;
  logic [3:0] bitCnt_r;
  logic [1:0] byteCnt_r;
  logic [3:0] dumCnt_r;
  logic [20:0] addr_r;
  logic [20:0] addrNxt;
  logic [7:0] pref_r;
  logic memEnD_r;
  logic [7:0] outSh_r;
  logic [3:0] outLeft_r;
  logic [7:0] curByte;
  logic [3:0] avail;
  logic cont_r;
  logic [7:0] contCmd_r;
  logic [3:0] protoW, addrW, dataW, inW;
  logic isDdr, hasMode, inSample, outEv, byteDone;
  logic startFetch, consumeEv, modeDone, cmdOk;

  assign riseEv = sckSh_r[1] & ~sckSh_r[2];
  assign fallEv = ~sckSh_r[1] & sckSh_r[2];
  assign csHigh = csSh_r[1];
  assign csFall = ~csSh_r[1] & csSh_r[2];
  assign run = !csHigh && !csFall;
  assign isDdr = (cmd_r == smr_pkg::OPC_DDR);
  assign hasMode = (cmd_r != smr_pkg::OPC_READ);

  // Line widths per phase for the command in flight
  always_comb
  begin
    unique case (cfg.protocolMode)
      smr_pkg::PROTO_TWO: protoW = smr_pkg::W_TWO;
      smr_pkg::PROTO_FOUR: protoW = smr_pkg::W_FOUR;
      default: protoW = smr_pkg::W_ONE;
    endcase
    addrW = protoW;
    dataW = protoW;
    if (cfg.protocolMode == smr_pkg::PROTO_ONE)
    begin
      if (cmd_r == smr_pkg::OPC_DUAL_IO)
        addrW = smr_pkg::W_TWO;
      if (cmd_r == smr_pkg::OPC_DUAL_OUT || cmd_r == smr_pkg::OPC_DUAL_IO)
        dataW = smr_pkg::W_TWO;
      else if (cmd_r == smr_pkg::OPC_QUAD_OUT)
        dataW = smr_pkg::W_FOUR;
    end
    inW = (state_r == smr_pkg::ST_OPC) ? protoW : addrW;
  end

  // Double edge sampling applies to address and mode only; a fall only
  // finishes a byte, so the fall closing the last opcode clock is skipped
  assign inSample = riseEv || (isDdr && fallEv && bitCnt_r != 4'h0 &&
    (state_r == smr_pkg::ST_ADDR || state_r == smr_pkg::ST_MODE));
  assign outEv = fallEv || (isDdr && riseEv);

  // Input shift, widest lines hold the most significant bits
  always_comb
  begin
    unique case (inW)
      smr_pkg::W_TWO: shNxt = {shift_r[5:0], ioSync_r[1:0]};
      smr_pkg::W_FOUR: shNxt = {shift_r[3:0], ioSync_r};
      default: shNxt = {shift_r[6:0], ioSync_r[0]};
    endcase
  end

  assign byteDone = inSample && ((bitCnt_r + inW) == smr_pkg::BYTE_BITS);
  assign modeDone = run && state_r == smr_pkg::ST_MODE && byteDone;

  // Opcodes this engine accepts in the current protocol
  always_comb
  begin
    unique case (shNxt)
      smr_pkg::OPC_READ, smr_pkg::OPC_FAST: cmdOk = 1'b1;
      smr_pkg::OPC_DDR:
        cmdOk = (cfg.protocolMode == smr_pkg::PROTO_FOUR);
      smr_pkg::OPC_DUAL_OUT, smr_pkg::OPC_DUAL_IO:
        cmdOk = (cfg.protocolMode == smr_pkg::PROTO_ONE);
      smr_pkg::OPC_QUAD_OUT:
        cmdOk = (cfg.protocolMode == smr_pkg::PROTO_ONE) && cfg.quadEnable;
      default: cmdOk = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------
  // Deselect wins over everything so a cut frame never leaks state
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= smr_pkg::ST_OPC;
      cmd_r <= smr_pkg::CMD_RST;
      shift_r <= 8'h00;
      bitCnt_r <= 4'h0;
      byteCnt_r <= 2'h0;
      dumCnt_r <= 4'h0;
    end
    else if (csHigh)
    begin
      state_r <= smr_pkg::ST_OPC;
      bitCnt_r <= 4'h0;
      byteCnt_r <= 2'h0;
      dumCnt_r <= 4'h0;
    end
    else if (csFall)
    begin
      if (cont_r)
      begin
        state_r <= smr_pkg::ST_ADDR;
        cmd_r <= contCmd_r;
      end
      else
        state_r <= smr_pkg::ST_OPC;
    end
    else
    begin
      unique case (state_r)
        smr_pkg::ST_OPC, smr_pkg::ST_ADDR, smr_pkg::ST_MODE:
        begin
          if (inSample)
          begin
            shift_r <= shNxt;
            bitCnt_r <= byteDone ? 4'h0 : bitCnt_r + inW;
          end
          if (byteDone && state_r == smr_pkg::ST_OPC)
          begin
            cmd_r <= shNxt;
            state_r <= cmdOk ? smr_pkg::ST_ADDR : smr_pkg::ST_IGNORE;
          end
          else if (byteDone && state_r == smr_pkg::ST_ADDR)
          begin
            byteCnt_r <= byteCnt_r + 2'h1;
            if (byteCnt_r == smr_pkg::ADDR_LAST_BYTE)
            begin
              if (hasMode)
                state_r <= smr_pkg::ST_MODE;
              else if (cfg.latencyCode == 4'h0)
                state_r <= smr_pkg::ST_DATA;
              else
                state_r <= smr_pkg::ST_DUMMY;
            end
          end
          else if (byteDone)
            state_r <= (cfg.latencyCode == 4'h0) ? smr_pkg::ST_DATA
              : smr_pkg::ST_DUMMY;
        end
        // Dummy cycles counted on rising clock edges
        smr_pkg::ST_DUMMY:
        begin
          if (riseEv)
          begin
            dumCnt_r <= dumCnt_r + 4'h1;
            if (dumCnt_r + 4'h1 == cfg.latencyCode)
              state_r <= smr_pkg::ST_DATA;
          end
        end
        smr_pkg::ST_DATA, smr_pkg::ST_IGNORE:
          state_r <= state_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address counter and array fetch
  // ----------------------------------------------------------------
  // Shifting keeps only 21 bits, so the top three are dropped
  assign addrNxt = {addr_r[12:0], shNxt};
  assign startFetch = run && state_r == smr_pkg::ST_ADDR && byteDone &&
    byteCnt_r == smr_pkg::ADDR_LAST_BYTE;
  assign consumeEv = run && state_r == smr_pkg::ST_DATA && outEv &&
    outLeft_r == 4'h0;

  // Next byte is fetched as soon as the current one is taken
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_r <= smr_pkg::ADDR_BASE;
      memReq_r <= '0;
    end
    else
    begin
      memReq_r.en <= 1'b0;
      if (consumeEv)
      begin
        addr_r <= addr_r + 21'h1;
        memReq_r.en <= 1'b1;
        memReq_r.addr <= addr_r + 21'h1;
      end
      else if (run && state_r == smr_pkg::ST_ADDR && byteDone)
      begin
        addr_r <= addrNxt;
        if (startFetch)
        begin
          memReq_r.en <= 1'b1;
          memReq_r.addr <= addrNxt;
        end
      end
    end
  end

  // Prefetch buffer, one cycle array latency
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      memEnD_r <= 1'b0;
      pref_r <= 8'h00;
    end
    else
    begin
      memEnD_r <= memReq_r.en;
      if (memEnD_r)
        pref_r <= memRdData;
    end
  end

  // ----------------------------------------------------------------
  // Data output
  // ----------------------------------------------------------------
  assign curByte = (outLeft_r == 4'h0) ? pref_r : outSh_r;
  assign avail = (outLeft_r == 4'h0) ? smr_pkg::BYTE_BITS : outLeft_r;

  // Bits change on the falling edge so the host samples on rising; double edge reads change on both edges
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ioOut_r <= 4'h0;
      ioOe_r <= smr_pkg::OE_OFF;
      outSh_r <= 8'h00;
      outLeft_r <= 4'h0;
    end
    else if (csHigh || state_r != smr_pkg::ST_DATA)
    begin
      ioOe_r <= smr_pkg::OE_OFF;
      outLeft_r <= 4'h0;
    end
    else if (outEv && !csFall)
    begin
      outLeft_r <= avail - dataW;
      unique case (dataW)
        smr_pkg::W_TWO:
        begin
          ioOe_r <= smr_pkg::OE_TWO;
          ioOut_r <= {2'b00, curByte[7:6]};
          outSh_r <= {curByte[5:0], 2'b00};
        end
        smr_pkg::W_FOUR:
        begin
          ioOe_r <= smr_pkg::OE_FOUR;
          ioOut_r <= curByte[7:4];
          outSh_r <= {curByte[3:0], 4'h0};
        end
        default:
        begin
          ioOe_r <= smr_pkg::OE_ONE;
          ioOut_r <= {2'b00, curByte[7], 1'b0};
          outSh_r <= {curByte[6:0], 1'b0};
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Continuous mode
  // ----------------------------------------------------------------
  // Double edge reads demand the whole byte; others the high nibble
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cont_r <= smr_pkg::CONT_RST;
      contCmd_r <= smr_pkg::CMD_RST;
    end
    else if (modeDone)
    begin
      contCmd_r <= cmd_r;
      if (isDdr)
        cont_r <= (shNxt == smr_pkg::MODE_DDR);
      else
        cont_r <= (shNxt[7:4] == smr_pkg::MODE_NIBBLE);
    end
  end

  assign contActive_r = cont_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence nibbleMatch;
    modeDone && !isDdr && shNxt[7:4] == smr_pkg::MODE_NIBBLE;
  endsequence
  sequence nibbleMiss;
    modeDone && !isDdr && shNxt[7:4] != smr_pkg::MODE_NIBBLE;
  endsequence
  sequence byteTaken;
    consumeEv;
  endsequence

  oe_released_a:
    assert property (csHigh |=> ioOe_r == smr_pkg::OE_OFF)
    else $error("data lines driven while deselected");
  oe_data_only_a:
    assert property (ioOe_r != smr_pkg::OE_OFF |-> state_r == smr_pkg::ST_DATA)
    else $error("data lines driven outside data phase");
  addr_step_a:
    assert property (byteTaken |=> addr_r == $past(addr_r) + 21'h1 ##0 memReq_r.en)
    else $error("address did not advance by one");
  addr_wrap_a:
    assert property (byteTaken ##0 addr_r == smr_pkg::ADDR_TOP
      |=> addr_r == smr_pkg::ADDR_BASE && memReq_r.addr == smr_pkg::ADDR_BASE)
    else $error("address did not wrap to zero");
  fetch_start_a:
    assert property (startFetch |=> memReq_r.en ##1 !memReq_r.en)
    else $error("start address not fetched");
  cont_enter_a:
    assert property (nibbleMatch |=> cont_r)
    else $error("continuous mode not entered");
  cont_leave_a:
    assert property (nibbleMiss |=> !cont_r)
    else $error("continuous mode not left");
  ddr_mode_a:
    assert property (modeDone && isDdr |=>
      cont_r == ($past(shNxt) == smr_pkg::MODE_DDR))
    else $error("double edge mode byte misjudged");
  cont_skip_a:
    assert property (csFall && cont_r |=> state_r == smr_pkg::ST_ADDR)
    else $error("opcode not skipped in continuous mode");
  ddr_quad_only_a:
    assert property (run && state_r == smr_pkg::ST_OPC && byteDone &&
      shNxt == smr_pkg::OPC_DDR && cfg.protocolMode != smr_pkg::PROTO_FOUR
      |=> state_r == smr_pkg::ST_IGNORE)
    else $error("double edge read accepted outside four-line mode");
  dummy_len_a:
    assert property (run && state_r == smr_pkg::ST_DUMMY && riseEv &&
      dumCnt_r + 4'h1 == cfg.latencyCode |=> state_r == smr_pkg::ST_DATA)
    else $error("dummy count wrong");
  quad_lines_a:
    assert property (run && state_r == smr_pkg::ST_DATA && outEv &&
      dataW == smr_pkg::W_FOUR |=> ioOe_r == smr_pkg::OE_FOUR &&
      ioOut_r == $past(curByte[7:4]))
    else $error("four-line data order wrong");

endmodule : smr_read_engine
`default_nettype wire

// ==== test/smr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module smr_host_model (
  input wire logic core_clk,
  input wire logic [3:0] pinLvl,
  output logic sckPin,
  output logic csPin_n,
  output logic [3:0] hostOut,
  output logic [3:0] hostOe
);
  logic [3:0] got;

  // ------------------------------
  // Host side of the link
  // ------------------------------
  // Parked in clock mode 0, deselected, lines released
  initial
  begin
    sckPin = 1'b0;
    csPin_n = 1'b1;
    hostOut = 4'h0;
    hostOe = 4'h0;
    got = 4'h0;
  end

  // Select changes only while the clock is parked low
  task automatic sel(input logic on);
    @(posedge core_clk);
    #2;
    csPin_n = ~on;
  endtask : sel

  // Half an sck period of four core cycles; lines move mid-way so they
  // are settled at either edge, read-back taken just before the edge
  task automatic half(input logic lvl, input logic [3:0] d,
                      input logic [3:0] oe);
    repeat (2) @(posedge core_clk);
    #2;
    hostOut = d;
    hostOe = oe;
    @(posedge core_clk);
    #20;
    got = pinLvl;
    @(posedge core_clk);
    #2;
    sckPin = lvl;
  endtask : half

  // Send nb bits MSB first, w lines wide, on one or both edges
  task automatic put(input logic [31:0] v, input int nb, input int w,
                     input logic ddr);
    logic [3:0] m;
    logic [3:0] c;
    m = 4'((1 << w) - 1);
    for (int i = nb - w; i >= 0; i -= w)
    begin
      c = 4'(v >> i) & m;
      if (ddr)
        half(~sckPin, c, m);
      else
      begin
        half(1'b1, c, m);
        half(1'b0, c, m);
      end
    end
  endtask : put

  // Latency clocks with lines let go; select stays low throughout
  task automatic dummies(input int n);
    repeat (n)
    begin
      half(1'b1, 4'h0, 4'h0);
      half(1'b0, 4'h0, 4'h0);
    end
  endtask : dummies

  // Collect one byte; single-line data comes back on line 1
  task automatic get(input int w, input logic ddr, output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8; i += w)
    begin
      half(ddr ? ~sckPin : 1'b1, 4'h0, 4'h0);
      b = 8'(b << w)
        | 8'(w == 1 ? {3'h0, got[1]} : got & 4'((1 << w) - 1));
      if (!ddr)
        half(1'b0, 4'h0, 4'h0);
    end
  endtask : get
endmodule : smr_host_model
`default_nettype wire

// ==== test/test_serial_memory_read_commands.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_serial_memory_read_commands;
  logic core_clk;
  logic rst;
  logic sckPin;
  logic csPin_n;
  logic [3:0] hostOut;
  logic [3:0] hostOe;
  logic [3:0] pinLvl;
  logic [3:0] junk = 4'h9;
  logic [7:0] memRdData = 8'h00;
  logic [3:0] ioOut_r;
  logic [3:0] ioOe_r;
  logic contActive_r;
  logic xe;
  smr_pkg::smr_cfg_t cfg;
  smr_pkg::smr_memreq_t memReq_r;
  int n_mismatch;
  int n_tests;
  int ci;
  logic [7:0] opcs [10] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b,
                            8'h03, 8'h0b, 8'h03, 8'h0b, 8'h0d};
  int pws [10] = '{0, 0, 0, 0, 0, 1, 1, 2, 2, 2};
  logic [7:0] bado [5] = '{8'h0d, 8'h3b, 8'hbb, 8'h6b, 8'h5a};
  int badp [5] = '{0, 1, 2, 0, 0};
  logic badq [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  // ------------------------------
  // Clock, pins and array
  // ------------------------------
  // Array content is a mix of all address bits, so a wrap shows
  function automatic logic [7:0] memf(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {a[20:16], 3'h5};
  endfunction : memf

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Released lines float to a level that changes every cycle
  always @(posedge core_clk)
    junk <= junk + 4'h5;
  assign pinLvl = (ioOe_r & ioOut_r) | (~ioOe_r & hostOe & hostOut)
    | (~ioOe_r & ~hostOe & junk);

  // Array answers in the cycle after each request
  always @(posedge core_clk)
    if (memReq_r.en)
      memRdData <= memf(memReq_r.addr);

  smr_read_engine dut (
    .core_clk(core_clk),
    .rst(rst),
    .sckPin(sckPin),
    .csPin_n(csPin_n),
    .ioIn(pinLvl),
    .cfg(cfg),
    .memRdData(memRdData),
    .ioOut_r(ioOut_r),
    .ioOe_r(ioOe_r),
    .memReq_r(memReq_r),
    .contActive_r(contActive_r)
  );

  smr_host_model host (
    .core_clk(core_clk),
    .pinLvl(pinLvl),
    .sckPin(sckPin),
    .csPin_n(csPin_n),
    .hostOut(hostOut),
    .hostOe(hostOe)
  );

  // ------------------------------
  // Checks and frames
  // ------------------------------
  task automatic chk(input logic ok, input string what);
    n_tests++;
    if (!ok)
    begin
      n_mismatch++;
      $display("ERROR %0t ns: %s mismatch", $time, what);
    end
  endtask : chk

  // Deselect gap, long enough for the synchronisers
  task automatic gap();
    repeat (4) @(posedge core_clk);
    #2;
  endtask : gap

  // One read frame; opcode left out while continuous mode is expected
  task automatic rd(input logic [7:0] opc, input logic [23:0] a,
                    input logic [7:0] md, input int n);
    int pw;
    int aw;
    int dw;
    logic ddr;
    logic [7:0] b;
    pw = 1 << cfg.protocolMode;
    aw = (opc == 8'hbb) ? 2 : pw;
    dw = (opc == 8'h3b || opc == 8'hbb) ? 2 : (opc == 8'h6b) ? 4 : pw;
    ddr = (opc == 8'h0d);
    host.sel(1'b1);
    if (!xe)
      host.put({24'h0, opc}, 8, pw, 1'b0);
    host.put({8'h0, a}, 24, aw, ddr);
    if (opc != 8'h03)
      host.put({24'h0, md}, 8, aw, ddr);
    host.dummies(int'(cfg.latencyCode));
    chk(ioOe_r === 4'h0, "early drive");
    for (int k = 0; k < n; k++)
    begin
      host.get(dw, ddr, b);
      chk(b === memf(21'(a[20:0] + k)), "data");
    end
    chk(ioOe_r === (dw == 4 ? 4'hf : dw == 2 ? 4'h3 : 4'h2), "lines");
    host.sel(1'b0);
    gap();
    chk(ioOe_r === 4'h0, "release");
    if (opc != 8'h03)
      xe = ddr ? (md == 8'ha5) : (md[7:4] == 4'ha);
    chk(contActive_r === xe, "continuous");
  endtask : rd

  // A command the engine must refuse; lines must stay released
  task automatic bad(input logic [7:0] opc);
    host.sel(1'b1);
    host.put({24'h0, opc}, 8, 1 << cfg.protocolMode, 1'b0);
    host.put($urandom, 32, 1 << cfg.protocolMode, 1'b0);
    chk(ioOe_r === 4'h0, "refused drive");
    host.sel(1'b0);
    gap();
    chk(contActive_r === 1'b0, "refused continuous");
  endtask : bad

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // ------------------------------
  // Main sequence and watchdog
  // ------------------------------
  initial
  begin
    logic [7:0] md;
    rst = 1'b1;
    cfg = '0;
    n_mismatch = 0;
    n_tests = 0;
    xe = 1'b0;
    ci = 0;
    void'($urandom(11));
    repeat (19) @(posedge core_clk);
    #2;
    chk(ioOe_r === 4'h0 && memReq_r.en === 1'b0 && contActive_r === 1'b0,
        "reset");
    @(posedge core_clk);
    #2;
    rst = 1'b0;
    gap();
    $display("Test reset done");
    // Each command and mode: enter continuous mode where there is a mode byte, then a miss at the top
    for (int i = 0; i < 10; i++)
    begin
      cfg.protocolMode = smr_pkg::smr_proto_t'(2'(pws[i]));
      cfg.quadEnable = 1'b1;
      cfg.latencyCode = (i == 9) ? 4'hf : 4'(i % 4);
      rd(opcs[i], 24'($urandom), opcs[i] == 8'h0d ? 8'ha5 : 8'ha3, 2);
      rd(opcs[i], 24'hfffffe, opcs[i] == 8'h0d ? 8'ha0 : 8'h5a, 3);
    end
    $display("Test commands done");
    for (int i = 0; i < 5; i++)
    begin
      cfg.protocolMode = smr_pkg::smr_proto_t'(2'(badp[i]));
      cfg.quadEnable = badq[i];
      bad(bado[i]);
    end
    $display("Test refusals done");
    // Random traffic; continuous frames keep the stored command
    for (int j = 0; j < 15; j++)
    begin
      if (!xe)
        ci = $urandom_range(9, 0);
      cfg.protocolMode = smr_pkg::smr_proto_t'(2'(pws[ci]));
      cfg.quadEnable = 1'b1;
      cfg.latencyCode = 4'($urandom_range(15, opcs[ci] == 8'h0d));
      md = 8'($urandom);
      if ($urandom_range(1, 0) == 1)
        md = (opcs[ci] == 8'h0d) ? 8'ha5 : {4'ha, md[3:0]};
      rd(opcs[ci], 24'($urandom), md, $urandom_range(4, 1));
    end
    $display("Test random done");
    tally_and_finish();
  end

  // Whole run needs well under 1 ms; give it over four times that
  initial
  begin
    #4000000;
    n_mismatch++;
    $display("ERROR %0t ns: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : test_serial_memory_read_commands
`default_nettype wire
